// File: hdl/bbx_consts.svh
// constants for the bit and byte instruction execution block
`ifndef BBX_CONSTS_SVH
`define BBX_CONSTS_SVH

// ==========================================================
// instruction word layout
`define BBX_INSTR_W 14
`define BBX_FADDR_W 7
`define BBX_FADDR_LSB 0
`define BBX_DEST_POS 7
`define BBX_BSEL_LSB 7
`define BBX_BSEL_W 3
`define BBX_ACCUM_CLEAR_CODE 14'h0103
`define BBX_WATCHDOG_CLEAR_CODE 14'h0064

// ==========================================================
// timing: oscillator periods per instruction cycle
`define BBX_PHASES_PER_CYCLE 4
`define BBX_LAST_PHASE 2'h3

// ==========================================================
// register offsets (byte addresses)
`define BBX_CTRL_OFS 12'h000
`define BBX_STATUS_OFS 12'h004
`define BBX_ACCUM_OFS 12'h008
`define BBX_WDOG_OFS 12'h00c
`define BBX_FILE_BASE 12'h200

// ==========================================================
// field positions
`define BBX_CTRL_RUN_POS 0
`define BBX_CTRL_WDT_EN_POS 1
`define BBX_CTRL_SLEEP_POS 2
`define BBX_STAT_ZERO_POS 0
`define BBX_STAT_EXPIRY_POS 1
`define BBX_STAT_SLEEP_POS 2
`define BBX_STAT_NOP_POS 3
`define BBX_WDOG_PRESC_LSB 8

// ==========================================================
// reset values
`define BBX_RUN_RST 1'b1
`define BBX_WDT_EN_RST 1'b0
`define BBX_ACCUM_RST 8'h00
`define BBX_FILE_RST 8'h00

`endif

// File: hdl/bbx_pkg.sv
// types shared by the bit and byte instruction execution block
package bbx_pkg;

    // ==========================================================
    // decoded operations
    typedef enum logic [2:0] {
        no_effect_op,
        bit_clear_op,
        bit_set_op,
        bit_test_skip_clear_op,
        accum_clear_op,
        watchdog_clear_op,
        complement_op,
        decrement_op
    } bbx_op_e;

    // ==========================================================
    // decoded instruction
    typedef struct packed {
        bbx_op_e op;
        logic dest_file;
        logic [2:0] bit_sel;
        logic [6:0] faddr;
    } bbx_instr_s;

    // ==========================================================
    // latched bus address phase
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
    } bbx_aphase_s;

endpackage : bbx_pkg

// File: hdl/bbx_decode.sv
// instruction word decoder
`timescale 1ns/1ps
`default_nettype none
`include "bbx_consts.svh"

module bbx_decode (
    // instruction word in
    input wire logic [13:0] instr_word,
    // decoded out
    output bbx_pkg::bbx_instr_s decoded
);

    // ==========================================================
    // decode
    always_comb begin
        decoded.dest_file = instr_word[`BBX_DEST_POS];
        decoded.bit_sel = instr_word[`BBX_BSEL_LSB +: `BBX_BSEL_W];
        decoded.faddr = instr_word[`BBX_FADDR_LSB +: `BBX_FADDR_W];
        // wildcards keep operand bits out of the match; accumulator clear and watchdog clear compare every bit
        casez (instr_word)
            14'b01_00??_????_????: decoded.op = bbx_pkg::bit_clear_op;
            14'b01_01??_????_????: decoded.op = bbx_pkg::bit_set_op;
            14'b01_10??_????_????: decoded.op = bbx_pkg::bit_test_skip_clear_op;
            `BBX_ACCUM_CLEAR_CODE: decoded.op = bbx_pkg::accum_clear_op;
            `BBX_WATCHDOG_CLEAR_CODE: decoded.op = bbx_pkg::watchdog_clear_op;
            14'b00_1001_????_????: decoded.op = bbx_pkg::complement_op;
            14'b00_0011_????_????: decoded.op = bbx_pkg::decrement_op;
            default: decoded.op = bbx_pkg::no_effect_op;
        endcase
    end

endmodule : bbx_decode
`default_nettype wire

// File: hdl/bbx_file_regs.sv
// file register array with two read ports and one write port
`timescale 1ns/1ps
`default_nettype none
`include "bbx_consts.svh"

module bbx_file_regs #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // read ports
    input wire logic [AW-1:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [7:0] rdata_b
);

    logic [7:0] mem [DEPTH];

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
            $error("bbx_file_regs: DEPTH does not fit AW");
        end
    endgenerate

    // ==========================================================
    // storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `BBX_FILE_RST;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule : bbx_file_regs
`default_nettype wire

// File: hdl/bbx_core.sv
// bit and byte instruction execution core with its register slave
//
// Contract
// - one instruction cycle each; skips take a second cycle as no-operation
// - four oscillator periods make one instruction cycle
// - destination bit 0 writes accumulator, 1 writes addressed file register
// - don't-care instruction bits accept either value; the decoder matches accumulator clear only as the exact word 14'h0103
// - bit clear zeroes selected file bit in one cycle, no flags
// - bit set raises selected file bit in one cycle, no flags
// - test-skip-if-clear on zero bit discards prefetched word, two cycles
// - accumulator clear loads zero and sets zero flag
// - complement writes inverted file value to destination, updates zero
// - watchdog clear zeroes counter and prescaler, sets both status flags; a timeout or sleep write in the same cycle still lowers its flag
// - decrement writes file value minus one to destination, updates zero
// - each instruction is one 14-bit word, opcode then operands
// - file address operand is seven bits, locations 0x00 to 0x7f
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bbx_consts.svh"

module bbx_core #(
    parameter int PRESC_W = 8,
    parameter int FILE_DEPTH = 128
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // instruction fetch path
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic instr_discard,
    // instruction cycle rate and watchdog
    output logic cycle_clk_out,
    output logic wdt_expired
);

    localparam int FAW = 7;

    generate
        if (PRESC_W < 1 || PRESC_W > 16) begin : g_bad_presc
            $error("bbx_core: PRESC_W must be 1 to 16");
        end
        if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_depth
            $error("bbx_core: FILE_DEPTH must be 1 to 128");
        end
    endgenerate

    // ==========================================================
    // state
    logic [1:0] phase;
    logic run;
    logic wdt_en;
    logic nop_pending;
    logic [7:0] accum;
    logic zero;
    logic expiry_flag_n;
    logic sleep_entry_flag_n;
    logic [7:0] watchdog_counter;
    logic [PRESC_W-1:0] wdt_presc;
    bbx_pkg::bbx_aphase_s aphase;
    logic dphase_wr;

    // ==========================================================
    // decoded instruction and file access
    bbx_pkg::bbx_instr_s dec;
    logic [7:0] file_rd;
    logic [7:0] bus_file_rd;
    logic [7:0] result;
    logic bit_val;
    logic cyc_end;
    logic take;
    logic exec;
    logic skip;
    logic core_we;
    logic bus_file_we;
    logic rf_we;
    logic [FAW-1:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic acc_dest;
    logic zero_upd;
    logic wdt_tick;
    logic wdt_wrap;

    bbx_decode u_decode (
        .instr_word(instr_word),
        .decoded(dec)
    );

    bbx_file_regs #(
        .DEPTH(FILE_DEPTH),
        .AW(FAW)
    ) u_file (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .raddr_a(dec.faddr),
        .rdata_a(file_rd),
        .raddr_b(haddr[FAW+1:2]),
        .rdata_b(bus_file_rd)
    );

    // ==========================================================
    // bus helpers
    function automatic logic in_file(input logic [11:0] a);
        in_file = a >= `BBX_FILE_BASE && a < (`BBX_FILE_BASE + 12'(FILE_DEPTH * 4));
    endfunction : in_file

    function automatic logic [31:0] read_word(input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == `BBX_CTRL_OFS) begin
            w[`BBX_CTRL_RUN_POS] = run;
            w[`BBX_CTRL_WDT_EN_POS] = wdt_en;
        end else if (a == `BBX_STATUS_OFS) begin
            w[`BBX_STAT_ZERO_POS] = zero;
            w[`BBX_STAT_EXPIRY_POS] = expiry_flag_n;
            w[`BBX_STAT_SLEEP_POS] = sleep_entry_flag_n;
            w[`BBX_STAT_NOP_POS] = nop_pending;
        end else if (a == `BBX_ACCUM_OFS) begin
            w[7:0] = accum;
        end else if (a == `BBX_WDOG_OFS) begin
            w[7:0] = watchdog_counter;
            w[`BBX_WDOG_PRESC_LSB +: PRESC_W] = wdt_presc;
        end
        read_word = w;
    endfunction : read_word

    // ==========================================================
    // instruction cycle sequencing
    // the phase counter free-runs so the cycle rate output never stops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign cyc_end = phase == `BBX_LAST_PHASE;
    assign instr_ready = run && cyc_end;
    assign take = instr_ready && instr_valid;
    assign exec = take && !nop_pending;
    assign instr_discard = take && nop_pending;
    assign bit_val = file_rd[dec.bit_sel];
    assign skip = exec && dec.op == bbx_pkg::bit_test_skip_clear_op && !bit_val;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cycle_clk_out <= 1'b0;
        end else begin
            cycle_clk_out <= phase == 2'h1 || phase == 2'h2;
        end
    end

    // second cycle of a taken skip consumes the prefetched word as a no-operation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nop_pending <= 1'b0;
        end else if (skip) begin
            nop_pending <= 1'b1;
        end else if (instr_discard) begin
            nop_pending <= 1'b0;
        end
    end

    // ==========================================================
    // execution datapath
    always_comb begin
        result = file_rd;
        core_we = 1'b0;
        acc_dest = 1'b0;
        zero_upd = 1'b0;
        unique case (dec.op)
            bbx_pkg::bit_clear_op: begin
                result[dec.bit_sel] = 1'b0;
                core_we = exec;
            end
            bbx_pkg::bit_set_op: begin
                result[dec.bit_sel] = 1'b1;
                core_we = exec;
            end
            bbx_pkg::complement_op: begin
                result = ~file_rd;
                core_we = exec && dec.dest_file;
                acc_dest = exec && !dec.dest_file;
                zero_upd = exec;
            end
            bbx_pkg::decrement_op: begin
                result = file_rd - 8'h01;
                core_we = exec && dec.dest_file;
                acc_dest = exec && !dec.dest_file;
                zero_upd = exec;
            end
            bbx_pkg::accum_clear_op: begin
                result = 8'h00;
                acc_dest = exec;
                zero_upd = exec;
            end
            bbx_pkg::bit_test_skip_clear_op,
            bbx_pkg::watchdog_clear_op,
            bbx_pkg::no_effect_op: begin
                result = file_rd;
            end
        endcase
    end

    // core owns the write port while running; bus writes only land when halted
    assign bus_file_we = dphase_wr && !run && in_file(aphase.addr);
    assign rf_we = core_we || bus_file_we;
    assign rf_waddr = core_we ? dec.faddr : aphase.addr[FAW+1:2];
    assign rf_wdata = core_we ? result : hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accum <= `BBX_ACCUM_RST;
        end else if (acc_dest) begin
            accum <= result;
        end else if (dphase_wr && aphase.addr == `BBX_ACCUM_OFS) begin
            accum <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero <= 1'b0;
        end else if (zero_upd) begin
            zero <= result == 8'h00;
        end
    end

    // ==========================================================
    // watchdog prescaler, advanced once per instruction cycle, and counter, advanced on each prescaler wrap
    assign wdt_tick = wdt_en && cyc_end;
    assign wdt_wrap = wdt_tick && (&wdt_presc) && (&watchdog_counter);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_presc <= '0;
            watchdog_counter <= 8'h00;
        end else if (exec && dec.op == bbx_pkg::watchdog_clear_op) begin
            wdt_presc <= '0;
            watchdog_counter <= 8'h00;
        end else if (wdt_tick) begin
            wdt_presc <= wdt_presc + PRESC_W'(1);
            if (&wdt_presc) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_expired <= 1'b0;
        end else begin
            wdt_expired <= wdt_wrap;
        end
    end

    // a timeout in the same cycle as a clear still lowers the flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            expiry_flag_n <= 1'b1;
        end else if (wdt_wrap) begin
            expiry_flag_n <= 1'b0;
        end else if (exec && dec.op == bbx_pkg::watchdog_clear_op) begin
            expiry_flag_n <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_entry_flag_n <= 1'b1;
        end else if (dphase_wr && aphase.addr == `BBX_CTRL_OFS
                     && hwdata[`BBX_CTRL_SLEEP_POS]) begin
            sleep_entry_flag_n <= 1'b0;
        end else if (exec && dec.op == bbx_pkg::watchdog_clear_op) begin
            sleep_entry_flag_n <= 1'b1;
        end
    end

    // ==========================================================
    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase <= '0;
            dphase_wr <= 1'b0;
        end else if (hready) begin
            dphase_wr <= hsel && htrans[1] && hwrite;
            if (hsel && htrans[1]) begin
                aphase.wr <= hwrite;
                aphase.addr <= {haddr[11:2], 2'b00};
            end
        end
    end

    // read data is prepared in the address phase so it stands from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (in_file({haddr[11:2], 2'b00})) begin
                hrdata <= {24'h00_0000, bus_file_rd};
            end else begin
                hrdata <= read_word({haddr[11:2], 2'b00});
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run <= `BBX_RUN_RST;
            wdt_en <= `BBX_WDT_EN_RST;
        end else if (dphase_wr && aphase.addr == `BBX_CTRL_OFS) begin
            run <= hwdata[`BBX_CTRL_RUN_POS];
            wdt_en <= hwdata[`BBX_CTRL_WDT_EN_POS];
        end
    end

endmodule : bbx_core
`default_nettype wire

// File: bench/bbx_core_asserts.sv
// port checks for the bit and byte execution core
`timescale 1ns/1ps
`default_nettype none
`include "bbx_consts.svh"

module bbx_core_asserts #(
    parameter int PRESC_W = 8,
    parameter int FILE_DEPTH = 128
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // fetch path
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic instr_discard,
    // rate and watchdog
    input wire logic cycle_clk_out,
    input wire logic wdt_expired
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic take;
    logic skip_seen;
    assign take = instr_valid && instr_ready;

    // ==========================================
    // helper
    // the pending skip survives idle slots, so it is only updated on a take
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skip_seen <= 1'b0;
        end else if (take) begin
            skip_seen <= !instr_discard && (instr_word[13:10] == 4'b0110);
        end
    end

    // ==========================================
    // properties
    AST_READY_GAP: assert property (instr_ready |=> !instr_ready [*3])
        else $error("fetch slot closer than four clocks");
    AST_CLK_SHAPE: assert property ($rose(cycle_clk_out) |=> cycle_clk_out ##1 !cycle_clk_out)
        else $error("cycle clock not high for two clocks");
    AST_DISC_TAKE: assert property (instr_discard |-> take)
        else $error("discard without a taken word");
    AST_DISC_CAUSE: assert property (instr_discard |-> skip_seen)
        else $error("discard without a preceding test");
    AST_DISC_ONCE: assert property (instr_discard |=> !instr_discard [*4])
        else $error("two discards in a row");
    AST_NO_SKIP: assert property (take && !instr_discard && instr_word[13:10] != 4'b0110
        |=> !instr_discard [*4])
        else $error("discard after a plain instruction");
    AST_WDT_PULSE: assert property (wdt_expired |=> !wdt_expired)
        else $error("expiry pulse longer than one clock");
    AST_WDT_CLEAR: assert property (take && !instr_discard
        && instr_word == `BBX_WATCHDOG_CLEAR_CODE |-> ##3 !wdt_expired [*8])
        else $error("expiry right after watchdog clear");
endmodule : bbx_core_asserts

bind bbx_core bbx_core_asserts #(.PRESC_W(PRESC_W), .FILE_DEPTH(FILE_DEPTH)) u_asserts (
    .hclk(hclk),
    .hresetn(hresetn),
    .instr_word(instr_word),
    .instr_valid(instr_valid),
    .instr_ready(instr_ready),
    .instr_discard(instr_discard),
    .cycle_clk_out(cycle_clk_out),
    .wdt_expired(wdt_expired)
);
`default_nettype wire

// File: bench/bbx_fetch_model.sv
// behavioural model of the instruction fetch path
`timescale 1ns/1ps
`default_nettype none

module bbx_fetch_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // handshake with the core
    input wire logic instr_ready,
    input wire logic stall,
    output logic [13:0] instr_word,
    output logic instr_valid
);
    logic [13:0] q[$];
    logic [13:0] last_word = 14'h0000;

    task automatic push(input logic [13:0] w);
        q.push_back(w);
    endtask : push

    function automatic logic busy();
        return (q.size() != 0) || (instr_valid === 1'b1);
    endfunction : busy

    // a word is held until taken; an idle line shows the inverse of the last word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_valid <= 1'b0;
            instr_word <= 14'h0000;
        end else if (!instr_valid || instr_ready) begin
            if (instr_valid) begin
                last_word = q.pop_front();
            end
            if (q.size() != 0 && !stall) begin
                instr_valid <= 1'b1;
                instr_word <= q[0];
            end else begin
                instr_valid <= 1'b0;
                instr_word <= ~last_word;
            end
        end
    end
endmodule : bbx_fetch_model
`default_nettype wire

// File: bench/bbx_core_tb.sv
// self-checking bench for the bit and byte execution core
`timescale 1ns/1ps
`default_nettype none
`include "bbx_consts.svh"
`define CHK(act, exp) begin \
    n_checks++; \
    if ((act) !== (exp)) begin \
        num_errors++; \
        $display("CHECK FAILED t=%0t got %h want %h", $time, (act), (exp)); \
    end \
end

module bbx_core_tb;
    // ==========================================
    // signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic stall = 1'b0;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [13:0] instr_word;
    logic instr_valid;
    logic instr_ready;
    logic instr_discard;
    logic wdt_expired;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_disc = 0;

    always #2.5 hclk = ~hclk;
    assign hready = hreadyout;

    bbx_core #(.PRESC_W(2)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .instr_word(instr_word), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr_discard(instr_discard),
        .cycle_clk_out(), .wdt_expired(wdt_expired)
    );

    bbx_fetch_model fetch (
        .hclk(hclk), .hresetn(hresetn), .instr_ready(instr_ready),
        .stall(stall), .instr_word(instr_word), .instr_valid(instr_valid)
    );

    // ==========================================
    // tasks
    task automatic bus_xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus_xfer

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        bus_xfer(a, 1'b0, 32'h0);
        `CHK(rd, e)
    endtask : rd_chk

    // bounded wait: a hung core must not stall the run
    task automatic drain();
        for (int i = 0; i < 400 && fetch.busy(); i++) @(posedge hclk);
        repeat (2) @(posedge hclk);
    endtask : drain

    function automatic logic [13:0] bitop(logic [1:0] k, logic [2:0] b, logic [6:0] f);
        return {2'b01, k, b, f};
    endfunction : bitop

    function automatic logic [13:0] byteop(logic [3:0] k, logic d, logic [6:0] f);
        return {2'b00, k, d, f};
    endfunction : byteop

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge hclk) begin
        cyc++;
        if (instr_discard === 1'b1 && instr_valid === 1'b1) begin
            n_disc++;
        end
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end

    // ==========================================
    // sequence
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(12'h004, 32'h6);
        rd_chk(12'h100, 32'h0);
        bus_xfer(12'h000, 1'b1, 32'h0);
        bus_xfer(12'h214, 1'b1, 32'hc7);
        bus_xfer(12'h218, 1'b1, 32'h0a);
        bus_xfer(12'h21c, 1'b1, 32'h13);
        bus_xfer(12'h220, 1'b1, 32'h01);
        bus_xfer(12'h3fc, 1'b1, 32'h00);
        bus_xfer(12'h000, 1'b1, 32'h1);
        fetch.push(bitop(2'b00, 3'h7, 7'h05));
        fetch.push(bitop(2'b01, 3'h7, 7'h06));
        fetch.push(byteop(4'h9, 1'b0, 7'h07));
        drain();
        rd_chk(12'h214, 32'h47);
        rd_chk(12'h218, 32'h8a);
        rd_chk(12'h21c, 32'h13);
        rd_chk(12'h008, 32'hec);
        rd_chk(12'h004, 32'h6);
        fetch.push(byteop(4'h3, 1'b1, 7'h08));
        fetch.push(bitop(2'b01, 3'h3, 7'h05));
        drain();
        rd_chk(12'h220, 32'h0);
        rd_chk(12'h214, 32'h4f);
        rd_chk(12'h004, 32'h7);
        fetch.push(byteop(4'h3, 1'b1, 7'h7f));
        fetch.push(byteop(4'h3, 1'b0, 7'h07));
        fetch.push(14'h0000);
        drain();
        rd_chk(12'h3fc, 32'hff);
        rd_chk(12'h008, 32'h12);
        rd_chk(12'h004, 32'h6);
        fetch.push(`BBX_ACCUM_CLEAR_CODE);
        drain();
        rd_chk(12'h008, 32'h0);
        rd_chk(12'h004, 32'h7);
        fetch.push(bitop(2'b10, 3'h0, 7'h06));
        drain();
        // let the stall settle before queueing, so the model cannot present the word early
        stall <= 1'b1;
        @(posedge hclk);
        fetch.push(bitop(2'b01, 3'h0, 7'h06));
        repeat (12) @(posedge hclk);
        rd_chk(12'h004, 32'hf);
        stall <= 1'b0;
        fetch.push(bitop(2'b10, 3'h1, 7'h06));
        fetch.push(bitop(2'b01, 3'h2, 7'h06));
        drain();
        rd_chk(12'h218, 32'h8e);
        `CHK(n_disc, 1)
        bus_xfer(12'h000, 1'b1, 32'h3);
        for (int i = 0; i < 6000 && wdt_expired !== 1'b1; i++) @(posedge hclk);
        rd_chk(12'h004, 32'h5);
        bus_xfer(12'h000, 1'b1, 32'h5);
        rd_chk(12'h004, 32'h1);
        fetch.push(`BBX_WATCHDOG_CLEAR_CODE);
        drain();
        rd_chk(12'h00c, 32'h0);
        rd_chk(12'h004, 32'h7);
        test_done();
    end
endmodule : bbx_core_tb
`default_nettype wire
